// ---- line_tx_regs.svh ----
// register offsets, field positions, reset values and widths of the line output stage
`ifndef LINE_TX_REGS_SVH
`define LINE_TX_REGS_SVH

// ==========================================================
// register byte offsets
`define LTX_CONFIG_OFFSET 12'h000
`define LTX_STATUS_OFFSET 12'h004
`define LTX_ADDR_WIDTH 12

// ==========================================================
// configuration field positions
`define LTX_DIGITAL_RAIL_SELECT_BIT 0
`define LTX_TX_CODE_SELECT_BIT 1
`define LTX_TX_LINE_TRISTATE_BIT 2
`define LTX_FULL_BAUD_SELECT_BIT 3
`define LTX_TX_OUTPUT_POLARITY_BIT 4
`define LTX_CMI_SELECT_BIT 5
`define LTX_CONFIG_WIDTH 6

// configuration reset value: analog lines, tristate set, half baud
`define LTX_CONFIG_RESET 6'h04

// ==========================================================
// status field positions
`define LTX_UNDERRUN_BIT 0
`define LTX_FIFO_EMPTY_BIT 1
`define LTX_FIFO_FULL_BIT 2
`define LTX_MODE_LSB 4
`define LTX_LEVEL_LSB 8

// ==========================================================
// buffer shape
`define LTX_FIFO_DEPTH 16
`define LTX_FIFO_LEVEL_WIDTH 5

`endif

// ---- line_tx_pkg.sv ----
// types shared by the line output stage
`default_nettype none
package line_tx_pkg;

	// ==========================================================
	// one line bit as queued for transmission
	typedef struct packed {
		logic frame_start; // first bit of a frame
		logic mark_pos; // positive rail pulse or optical data bit
		logic mark_neg; // negative rail pulse
	} symbol_s;

	// ==========================================================
	// output mode derived from configuration
	typedef enum logic [1:0] {
		mode_analog,
		mode_dual_rail,
		mode_optical
	} line_mode_e;

	// ==========================================================
	// decoded configuration bits
	typedef struct packed {
		logic cmi_select;
		logic tx_output_polarity;
		logic full_baud_select;
		logic tx_line_tristate;
		logic tx_code_select;
		logic digital_rail_select;
	} config_s;

endpackage

`default_nettype wire

// ---- digital_line_transmit_outputs.sv ----
// transmit line output stage with symbol fifo and apb configuration slave
`timescale 1ns/10ps
`default_nettype none
`include "line_tx_regs.svh"

// ==========================================================
// synchronous fifo, flip-flop storage addressed by index
module symbol_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 16,
	parameter int LEVEL_WIDTH = 5
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [LEVEL_WIDTH-1:0] level
);
	localparam int PTR_WIDTH = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH]; // word storage
	logic [PTR_WIDTH-1:0] wr_ptr; // next slot to fill
	logic [PTR_WIDTH-1:0] rd_ptr; // next slot to drain
	logic push; // word accepted this cycle
	logic pop; // word delivered this cycle
	logic [LEVEL_WIDTH-1:0] next_level; // fill after this cycle

	assign out_valid = (level != '0);
	assign out_data = store[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// fill after this cycle; simultaneous push and pop leaves it alone
	always_comb begin
		next_level = level;
		if (push && !pop) begin
			next_level = level + LEVEL_WIDTH'(1);
		end else if (pop && !push) begin
			next_level = level - LEVEL_WIDTH'(1);
		end
	end

	// storage write, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
			in_ready <= 1'b1; // empty after reset
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + PTR_WIDTH'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + PTR_WIDTH'(1);
			end
			level <= next_level;
			// registered from the next fill so ready comes straight from a flop
			in_ready <= (next_level != LEVEL_WIDTH'(DEPTH));
		end
	end
endmodule // symbol_fifo

// ==========================================================
// top: line output stage
module digital_line_transmit_outputs (
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LTX_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// symbol stream from the framer
	input wire logic sym_valid,
	output logic sym_ready,
	input wire line_tx_pkg::symbol_s sym_data,
	// line clock pin from the driver side
	input wire logic tx_line_clock,
	// line pins, each with its output enable
	output logic tx_rail_positive,
	output logic tx_rail_positive_oe,
	output logic tx_rail_negative,
	output logic tx_rail_negative_oe,
	output logic tx_optical_data,
	output logic tx_optical_data_oe,
	output logic tx_frame_marker,
	output logic tx_frame_marker_oe,
	output logic analog_tx_line_oe
);
	// ==========================================================
	// declarations
	line_tx_pkg::config_s cfg; // software configuration
	line_tx_pkg::line_mode_e mode; // decoded output mode
	line_tx_pkg::symbol_s head; // symbol at fifo head
	line_tx_pkg::symbol_s cur; // symbol being sent
	logic head_valid; // fifo holds a symbol
	logic pop; // take head on a rising line clock
	logic [`LTX_FIFO_LEVEL_WIDTH-1:0] level; // fifo fill
	logic clk_meta; // first synchroniser stage
	logic clk_sync; // second synchroniser stage
	logic clk_prev; // delayed copy for edge detect
	logic line_rise; // rising edge of line clock
	logic line_fall; // falling edge of line clock
	logic underrun; // sticky: line clock found fifo empty
	logic digital_drive; // digital pins may leave tristate
	logic pulse_pos; // positive rail pulse, active high inside
	logic pulse_neg; // negative rail pulse, active high inside
	logic opt_level; // optical line level before polarity
	logic cmi_level; // running cmi level for ones
	logic marker; // frame marker before gating
	logic apb_access; // access phase not yet answered
	logic addr_ok; // address maps a register
	logic [31:0] read_word; // read mux

	// ==========================================================
	// mode decode
	always_comb begin
		if (!cfg.digital_rail_select) begin
			mode = line_tx_pkg::mode_analog;
		end else if (cfg.tx_code_select) begin
			mode = line_tx_pkg::mode_dual_rail;
		end else begin
			mode = line_tx_pkg::mode_optical;
		end
	end

	// digital pins leave tristate only when selected and not forced off
	assign digital_drive = cfg.digital_rail_select & ~cfg.tx_line_tristate;

	// ==========================================================
	// line clock synchroniser; the pin is asynchronous to clk
	always_ff @(posedge clk) begin
		if (!resetn) begin
			clk_meta <= 1'b0;
			clk_sync <= 1'b0;
			clk_prev <= 1'b0;
		end else begin
			clk_meta <= tx_line_clock;
			clk_sync <= clk_meta;
			clk_prev <= clk_sync;
		end
	end

	// edges seen two to three cycles late; fine at 2 MHz against 125 MHz
	assign line_rise = clk_sync & ~clk_prev;
	assign line_fall = ~clk_sync & clk_prev;

	// ==========================================================
	// symbol buffer
	symbol_fifo #(
		.WIDTH($bits(line_tx_pkg::symbol_s)),
		.DEPTH(`LTX_FIFO_DEPTH),
		.LEVEL_WIDTH(`LTX_FIFO_LEVEL_WIDTH)
	) u_symbol_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(sym_valid),
		.in_ready(sym_ready),
		.in_data(sym_data),
		.out_valid(head_valid),
		.out_ready(pop),
		.out_data(head),
		.level(level)
	);

	// drain only while a digital mode is live, so the fifo backs up otherwise
	assign pop = line_rise & digital_drive & (mode != line_tx_pkg::mode_analog);

	// ==========================================================
	// current symbol, taken on each rising line clock edge while a digital mode is live
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cur <= '0;
		end else if (pop) begin
			// empty fifo sends a space rather than stale data
			cur <= head_valid ? head : '0;
		end
	end

	// ==========================================================
	// rail pulses: half baud ends at falling edge, full baud holds the bit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pulse_pos <= 1'b0;
			pulse_neg <= 1'b0;
		end else if (pop) begin
			pulse_pos <= head_valid & head.mark_pos;
			pulse_neg <= head_valid & head.mark_neg;
		end else if (line_fall && !cfg.full_baud_select) begin
			pulse_pos <= 1'b0;
			pulse_neg <= 1'b0;
		end
	end

	// ==========================================================
	// optical level: nrz holds the bit, cmi sets the level at each rise and moves at the fall only for a zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			opt_level <= 1'b0;
			cmi_level <= 1'b0;
		end else if (pop) begin
			if (!cfg.cmi_select) begin
				opt_level <= head_valid & head.mark_pos;
			end else if (head_valid && head.mark_pos) begin
				// a one takes the opposite of the previous one
				opt_level <= ~cmi_level;
				cmi_level <= ~cmi_level;
			end else begin
				// a zero is low for the first half
				opt_level <= 1'b0;
			end
		end else if (line_fall && cfg.cmi_select && !cur.mark_pos) begin
			// zero goes high for its second half
			opt_level <= 1'b1;
		end
	end

	// ==========================================================
	// frame marker, aligned with the launched data bit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			marker <= 1'b0;
		end else if (pop) begin
			// only meaningful in single rail optical mode
			marker <= head_valid & head.frame_start
				& (mode == line_tx_pkg::mode_optical);
		end
	end

	// ==========================================================
	// registered pin levels, polarity applied to the rails and optical data but not the marker
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_rail_positive <= 1'b1;
			tx_rail_negative <= 1'b1;
			tx_optical_data <= 1'b0;
			tx_frame_marker <= 1'b0;
		end else begin
			// polarity clear gives active low rails
			tx_rail_positive <= cfg.tx_output_polarity ? pulse_pos : ~pulse_pos;
			tx_rail_negative <= cfg.tx_output_polarity ? pulse_neg : ~pulse_neg;
			// same bit clear gives active high optical data
			tx_optical_data <= cfg.tx_output_polarity ? ~opt_level : opt_level;
			tx_frame_marker <= marker;
		end
	end

	// ==========================================================
	// output enables; all pins float from reset until configured
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_rail_positive_oe <= 1'b0;
			tx_rail_negative_oe <= 1'b0;
			tx_optical_data_oe <= 1'b0;
			tx_frame_marker_oe <= 1'b0;
			analog_tx_line_oe <= 1'b0;
		end else begin
			// positive pin is shared: rail in dual mode, optical data otherwise
			tx_rail_positive_oe <= digital_drive & cfg.tx_code_select;
			tx_optical_data_oe <= digital_drive & ~cfg.tx_code_select;
			tx_rail_negative_oe <= digital_drive;
			tx_frame_marker_oe <= digital_drive;
			analog_tx_line_oe <= ~cfg.digital_rail_select & cfg.tx_code_select
				& ~cfg.tx_line_tristate;
		end
	end

	// ==========================================================
	// apb slave: one wait state, answer registered
	assign apb_access = psel & penable & ~pready;
	assign addr_ok = (paddr == `LTX_CONFIG_OFFSET) || (paddr == `LTX_STATUS_OFFSET);

	// read mux
	always_comb begin
		read_word = 32'h0000_0000;
		if (paddr == `LTX_CONFIG_OFFSET) begin
			read_word[`LTX_CONFIG_WIDTH-1:0] = cfg;
		end else if (paddr == `LTX_STATUS_OFFSET) begin
			read_word[`LTX_UNDERRUN_BIT] = underrun;
			read_word[`LTX_FIFO_EMPTY_BIT] = ~head_valid;
			read_word[`LTX_FIFO_FULL_BIT] = ~sym_ready;
			read_word[`LTX_MODE_LSB +: 2] = mode;
			read_word[`LTX_LEVEL_LSB +: `LTX_FIFO_LEVEL_WIDTH] = level;
		end
	end

	// bus answer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apb_access;
			pslverr <= apb_access & ~addr_ok;
			// unmapped and write answers read back zero
			prdata <= (apb_access && !pwrite) ? read_word : 32'h0000_0000;
		end
	end

	// configuration register write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg <= `LTX_CONFIG_RESET;
		end else if (apb_access && pwrite && paddr == `LTX_CONFIG_OFFSET) begin
			// changes land mid bit; software should reconfigure while tristated
			cfg <= pwdata[`LTX_CONFIG_WIDTH-1:0];
		end
	end

	// underrun sticky, write one to clear; a new event beats the clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			underrun <= 1'b0;
		end else if (pop && !head_valid) begin
			underrun <= 1'b1;
		end else if (apb_access && pwrite && paddr == `LTX_STATUS_OFFSET
			&& pwdata[`LTX_UNDERRUN_BIT]) begin
			underrun <= 1'b0;
		end
	end
endmodule // digital_line_transmit_outputs

`default_nettype wire

// ---- digital_line_transmit_outputs_props.sv ----
// assertion checker for the line output stage
`timescale 1ns/10ps
`default_nettype none
module line_tx_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_line_clock,
	input wire logic tx_rail_positive_oe,
	input wire logic tx_rail_negative_oe,
	input wire logic tx_optical_data_oe,
	input wire logic tx_frame_marker,
	input wire logic tx_frame_marker_oe,
	input wire logic analog_tx_line_oe
);
	// ==========
	// clocks since the raw line clock last rose, saturating
	logic line_q; // previous line clock sample
	logic [7:0] rise_age; // age of last rise
	always_ff @(posedge clk) begin
		line_q <= tx_line_clock;
		if (!resetn) begin
			rise_age <= 8'hff;
		end else if (tx_line_clock && !line_q) begin
			rise_age <= 8'h00;
		end else if (rise_age != 8'hff) begin
			rise_age <= rise_age + 8'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// one wait state, then the answer
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	AST_APB_WAIT: assert property ($rose(psel && penable) |-> s_one_wait)
		else $error("apb answer not after one wait state");
	AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready held");
	AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("pslverr without pready");
	AST_DUAL_EXCL: assert property (tx_rail_positive_oe |-> tx_rail_negative_oe &&
		!tx_optical_data_oe && !analog_tx_line_oe) else $error("dual rail enables wrong");
	AST_ANALOG_EXCL: assert property (analog_tx_line_oe |-> !tx_rail_negative_oe)
		else $error("analog and digital both enabled");
	AST_NEG_MARKER_OE: assert property (tx_rail_negative_oe == tx_frame_marker_oe)
		else $error("negative rail and marker enables differ");
	AST_MARKER_OPT: assert property (tx_frame_marker |-> tx_optical_data_oe)
		else $error("marker outside optical mode");
	// marker only moves a few clocks after a line clock rise, never after a fall
	AST_MARKER_LAUNCH: assert property ($changed(tx_frame_marker) && tx_frame_marker_oe
		&& $past(tx_frame_marker_oe) |-> rise_age inside {[8'h01:8'h08]})
		else $error("marker off edge");
	AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn |=>
		!(tx_rail_positive_oe || tx_rail_negative_oe || tx_frame_marker_oe
		|| tx_optical_data_oe || analog_tx_line_oe)) else $error("pin enabled in reset");
endmodule // line_tx_props
bind digital_line_transmit_outputs line_tx_props u_line_tx_props (.clk, .resetn, .psel,
	.penable, .pready, .pslverr, .tx_line_clock, .tx_rail_positive_oe, .tx_rail_negative_oe,
	.tx_optical_data_oe, .tx_frame_marker, .tx_frame_marker_oe, .analog_tx_line_oe);
`default_nettype wire

// ---- line_partner.sv ----
// far side model: line driver making the line clock and sampling the pins
`timescale 1ns/10ps
`default_nettype none
module line_partner (
	input wire logic clk,
	input wire logic run,
	output logic tx_line_clock,
	input wire logic [3:0] pins
);
	logic [3:0] mid_q [$]; // {positive, negative, optical, marker} at falls
	logic [3:0] end_q [$]; // same at rises
	logic [2:0] div; // half period of 8 clocks
	// ==========
	// clock stands low between bursts so the fifo is stalled
	always @(posedge clk) begin
		if (!run) begin
			div <= 3'h0;
			tx_line_clock <= 1'b0;
		end else begin
			div <= div + 3'h1;
			if (div == 3'h7) begin
				tx_line_clock <= !tx_line_clock;
			end
		end
	end
	// marker taken as is, no remote loop is ever set up
	always @(posedge tx_line_clock) end_q.push_back(pins);
	always @(negedge tx_line_clock) mid_q.push_back(pins);
endmodule // line_partner
`default_nettype wire

// ---- digital_line_transmit_outputs_tb_top.sv ----
// self-checking testbench for the line output stage
`timescale 1ns/10ps
`default_nettype none
`include "line_tx_regs.svh"
module digital_line_transmit_outputs_tb_top;
	logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, sym_valid = 1'b0, sym_ready, run = 1'b0, tx_line_clock;
	line_tx_pkg::symbol_s sym_data = '0;
	logic tx_rail_positive, tx_rail_positive_oe, tx_rail_negative, tx_rail_negative_oe;
	logic tx_optical_data, tx_optical_data_oe, tx_frame_marker, tx_frame_marker_oe;
	logic analog_tx_line_oe;
	logic [4:0] oes; // all pin enables
	int fail_count = 0, n_checks = 0;
	logic [2:0] syms [4] = '{3'h6, 3'h1, 3'h2, 3'h0}; // {frame start, positive, negative}
	assign oes = {tx_rail_positive_oe, tx_rail_negative_oe, tx_optical_data_oe,
		tx_frame_marker_oe, analog_tx_line_oe};
	always #4 clk = ~clk;
	digital_line_transmit_outputs u_digital_line_transmit_outputs (.clk, .resetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sym_valid, .sym_ready,
		.sym_data, .tx_line_clock, .tx_rail_positive, .tx_rail_positive_oe, .tx_rail_negative,
		.tx_rail_negative_oe, .tx_optical_data, .tx_optical_data_oe, .tx_frame_marker,
		.tx_frame_marker_oe, .analog_tx_line_oe);
	line_partner u_line_partner (.clk, .run, .tx_line_clock,
		.pins({tx_rail_positive, tx_rail_negative, tx_optical_data, tx_frame_marker}));
	// ==========
	// reporting
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ==========
	// apb master, one idle edge after each transfer
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int t;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (!pready && t < 20);
		if (!pready) begin
			fail_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, exp_err});
	endtask
	// valid held across symbols, dropped after the last
	task automatic push_n(input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			sym_valid <= 1'b1;
			sym_data <= line_tx_pkg::symbol_s'(syms[i % 4]);
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (!sym_ready && t < 50);
			if (!sym_ready) begin
				fail_count++;
				final_report();
			end
		end
		sym_valid <= 1'b0;
	endtask
	task automatic line_run(input int n);
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
	endtask
	// ==========
	// scenarios
	task automatic reset_values();
		chk({30'h0, tx_rail_positive, tx_rail_negative}, 32'h3);
		chk({27'h0, oes}, 32'h0);
		rdc(`LTX_CONFIG_OFFSET, 32'h4, 1'b0);
		rdc(`LTX_STATUS_OFFSET, 32'h2, 1'b0);
		rdc(12'h008, 32'h0, 1'b1);
	endtask
	task automatic oe_table();
		logic [5:0] cfg [7] = '{6'h04, 6'h00, 6'h02, 6'h06, 6'h05, 6'h01, 6'h03};
		logic [4:0] exp [7] = '{5'h00, 5'h00, 5'h01, 5'h00, 5'h00, 5'h0e, 5'h1a};
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, `LTX_CONFIG_OFFSET, {26'h0, cfg[i]});
			repeat (2) @(posedge clk);
			chk({27'h0, oes}, {27'h0, exp[i]});
		end
		apb(1'b1, `LTX_CONFIG_OFFSET, 32'h4);
	endtask
	task automatic fill_drain();
		push_n(16);
		@(posedge clk);
		chk({31'h0, sym_ready}, 32'h0);
		rdc(`LTX_STATUS_OFFSET, 32'h1004, 1'b0);
		apb(1'b1, `LTX_CONFIG_OFFSET, 32'h9);
		line_run(270);
		apb(1'b1, `LTX_CONFIG_OFFSET, 32'h4);
		rdc(`LTX_STATUS_OFFSET, 32'h3, 1'b0);
		apb(1'b1, `LTX_STATUS_OFFSET, 32'h1);
		rdc(`LTX_STATUS_OFFSET, 32'h2, 1'b0);
	endtask
	// four bits; mid sample at line fall, end sample at next rise
	task automatic stream(input logic [5:0] cfg, input logic [3:0] mask);
		logic [3:0] em, ee;
		logic [2:0] s;
		logic lvl; // cmi level of the last one sent
		lvl = 1'b0;
		push_n(4);
		apb(1'b1, `LTX_CONFIG_OFFSET, {26'h0, cfg});
		u_line_partner.mid_q.delete();
		u_line_partner.end_q.delete();
		line_run(76);
		apb(1'b1, `LTX_CONFIG_OFFSET, 32'h4);
		for (int k = 0; k < 4; k++) begin
			s = syms[k];
			// optical follows the polarity bit inverted; marker only in optical mode
			em = {s[1] ^ !cfg[4], s[0] ^ !cfg[4], s[1] ^ cfg[4], s[2] & !cfg[1]};
			ee = cfg[3] ? em : {!cfg[4], !cfg[4], em[1:0]};
			// cmi: a one alternates over the whole bit, a zero is low then high
			if (cfg[5] && s[1]) begin
				lvl = !lvl;
				em[1] = lvl ^ cfg[4];
				ee[1] = lvl ^ cfg[4];
			end else if (cfg[5]) begin
				em[1] = cfg[4];
				ee[1] = !cfg[4];
			end
			chk({28'h0, u_line_partner.mid_q[k] & mask}, {28'h0, em & mask});
			chk({28'h0, u_line_partner.end_q[k + 1] & mask}, {28'h0, ee & mask});
		end
	endtask
	// reset with the dual rail pins enabled and the line clock stopped drops every pin enable and the configuration
	task automatic reset_again();
		apb(1'b1, `LTX_CONFIG_OFFSET, 32'h3);
		repeat (2) @(posedge clk);
		chk({27'h0, oes}, 32'h1a);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk({27'h0, oes}, 32'h0);
		chk({30'h0, tx_rail_positive, tx_rail_negative}, 32'h3);
		rdc(`LTX_CONFIG_OFFSET, 32'h4, 1'b0);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		reset_values();
		oe_table();
		fill_drain();
		stream(6'h03, 4'hd);
		stream(6'h1b, 4'hd);
		stream(6'h09, 4'h3);
		stream(6'h19, 4'h3);
		stream(6'h21, 4'h3);
		reset_again();
		final_report();
	end
endmodule // digital_line_transmit_outputs_tb_top
`default_nettype wire
